// ### include/addsol_regs.svh
`ifndef ADDSOL_REGS_SVH
`define ADDSOL_REGS_SVH
// Word offsets on the 4-bit register port
`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h1
`define OFS_IRQ_ST 4'h2
`define OFS_IRQ_MASK 4'h3
`define OFS_ACTION 4'h4
`define OFS_VOLUME 4'h5
`define OFS_DWELL 4'h6
`define OFS_CLOSE 4'h7
`define OFS_RETRY 4'h8
`define OFS_NOADD 4'h9
`define OFS_LEAK_LIM 4'hA
`define OFS_LEAK_WIN 4'hB
`define OFS_PUMP_TO 4'hC
`define OFS_BLOCK_TO 4'hD
`define OFS_DELIVERED 4'hE
// Control bit positions
`define CTRL_START 0
`define CTRL_PUMP 1
`define CTRL_BLOCK 2
`define CTRL_CLEAR 3
// Alarm indices, shared by status, mask and action fields
`define AL_LEAK 0
`define AL_NOADD 1
`define AL_PUMP 2
`define AL_BLOCK 3
`define IRQ_DONE 4
// Reset values
`define RST_ACTION 8'h02
`define RST_VOLUME 16'h0001
`define RST_DWELL 16'h0000
`define RST_CLOSE 16'h01F4
`define RST_RETRY 16'h0002
`define RST_NOADD 16'h0002
`define RST_LEAK_LIM 16'h0064
`define RST_LEAK_WIN 16'h003C
`define RST_FB_TO 16'h000F
// Limits
`define MAX_RETRY 16'h0002
`define MIN_CLOSE 16'h01F4
`define MAX_CLOSE 16'h2710
`define MAX_DWELL 16'h7FFF
`define MAX_NOADD 16'h0009
`define MAX_LEAK_LIM 16'h03E7
`define MAX_LEAK_WIN 16'h0063
`define MAX_FB_TO 16'h00FF
// Timing
`define CLK_PERIOD_NS 100
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)
`define SEC_MS 18'h0_03E8
`endif

// ### include/addsol_pkg.sv
`default_nettype none
package addsol_pkg;
    typedef enum logic [1:0] {
        ACT_DISABLED = 2'h0,
        ACT_DISPLAY = 2'h1,
        ACT_SHUTDOWN = 2'h2,
        ACT_PAUSE = 2'h3
    } action_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ON = 2'h1,
        ST_OFF = 2'h3,
        ST_CLOSE = 2'h2
    } inj_state_t;
endpackage
`default_nettype wire

// ### hw/additive_solenoid_alarm_supervisor.sv
// The plain strobed port and the register addresses are this design's own decisions.
`include "addsol_regs.svh"
`default_nettype none
module additive_solenoid_alarm_supervisor
    import addsol_pkg::*;
#(
    parameter int MS_CYCLES = `MS_CYCLES,
    parameter int VOL_W = 16
) (
    input wire logic clk, // 10 MHz system clock
    input wire logic reset_n, // Asynchronous reset
    input wire logic [3:0] addr, // Register word address
    input wire logic [15:0] wdata, // Write data
    input wire logic wr_en, // Write strobe
    input wire logic rd_en, // Read strobe
    output logic [15:0] rdata, // Read data, cycle after rd_en
    input wire logic meter_pulse, // Additive meter pulse pin
    input wire logic pump_fb, // Pump running feedback pin
    input wire logic block_fb, // Block valve open feedback pin
    output logic solenoid, // Injection solenoid drive
    output logic alarm_ind, // Alarm indication output
    output logic alarm_shutdown, // Alarm shutdown output
    output logic batch_stop, // Running batch stopped
    output logic batch_pause, // Running batch paused
    output logic irq // Level interrupt
);

    localparam int DIV_W = $clog2(MS_CYCLES + 1);
    if (MS_CYCLES < 2 || VOL_W < 1 || VOL_W > 16) begin : g_check
        $error("Unsupported parameter values");
    end
    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    logic pump_demand_reg, block_demand_reg;
    logic [4:0] irq_mask_reg, irq_st_reg;
    logic [7:0] action_reg;
    logic [VOL_W-1:0] volume_reg, delivered_reg;
    logic [14:0] dwell_reg;
    logic [13:0] close_reg;
    logic [1:0] retry_reg, retry_cnt_reg;
    logic [3:0] noadd_reg;
    logic [9:0] leak_lim_reg;
    logic [6:0] leak_win_reg;
    logic [7:0] fb_to_reg [2];
    logic [DIV_W-1:0] ms_div_reg;
    logic [2:0] meter_sync_reg;
    inj_state_t state_reg;
    logic [17:0] ms_cnt_reg, noadd_ms_reg, leak_ms_reg;
    logic [17:0] dwell_tgt, off_tgt, close_tgt, noadd_tgt, leak_tgt;
    logic [10:0] leak_cnt_reg;
    logic ms_tick_reg, meter_edge, seen_reg, done_pulse_reg, noadd_fault_reg, solenoid_reg, leak_cond;
    logic ind_reg, sd_reg, stop_reg, pause_reg, irq_reg, wr_ctrl, start_req, clear_req;
    logic [15:0] rdata_reg;
    wire logic [1:0] fb_in, fb_level, fb_fault;
    wire logic [3:0] cond, alarm_vec, raise_vec, ind_vec, sd_vec, stop_vec, pause_vec;

    assign wr_ctrl = wr_en && addr == `OFS_CTRL;
    assign start_req = wr_ctrl && wdata[`CTRL_START];
    assign clear_req = wr_ctrl && wdata[`CTRL_CLEAR];
    assign dwell_tgt = 18'(dwell_reg);
    // Dwell zero still needs a short gap so a retry is a real reopen
    assign off_tgt = (dwell_reg == 15'h0000) ? 18'h0_0001 : dwell_tgt;
    assign close_tgt = 18'(close_reg);
    assign noadd_tgt = 18'(noadd_reg) * `SEC_MS;
    assign leak_tgt = 18'(leak_win_reg) * `SEC_MS;
    assign meter_edge = meter_sync_reg[1] && !meter_sync_reg[2];

    // Shared one-millisecond tick
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ms_div_reg <= '0;
            ms_tick_reg <= 1'h0;
        end else if (ms_div_reg == DIV_W'(MS_CYCLES - 1)) begin
            ms_div_reg <= '0;
            ms_tick_reg <= 1'h1;
        end else begin
            ms_div_reg <= ms_div_reg + 1'h1;
            ms_tick_reg <= 1'h0;
        end
    end

    // Third stage only feeds the edge detector
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meter_sync_reg <= '0;
        end else begin
            meter_sync_reg <= {meter_sync_reg[1:0], meter_pulse};
        end
    end

    // Configuration writes, clamped to the legal ranges
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pump_demand_reg <= 1'h0;
            block_demand_reg <= 1'h0;
            irq_mask_reg <= '0;
            action_reg <= `RST_ACTION;
            volume_reg <= VOL_W'(`RST_VOLUME);
            dwell_reg <= 15'(`RST_DWELL);
            close_reg <= 14'(`RST_CLOSE);
            retry_reg <= 2'(`RST_RETRY);
            noadd_reg <= 4'(`RST_NOADD);
            leak_lim_reg <= 10'(`RST_LEAK_LIM);
            leak_win_reg <= 7'(`RST_LEAK_WIN);
            fb_to_reg[0] <= 8'(`RST_FB_TO);
            fb_to_reg[1] <= 8'(`RST_FB_TO);
        end else if (wr_en) begin
            case (addr)
                `OFS_CTRL: begin
                    pump_demand_reg <= wdata[`CTRL_PUMP];
                    block_demand_reg <= wdata[`CTRL_BLOCK];
                end
                `OFS_IRQ_MASK: irq_mask_reg <= wdata[4:0];
                `OFS_ACTION: action_reg <= wdata[7:0];
                `OFS_VOLUME: volume_reg <= wdata[VOL_W-1:0];
                `OFS_DWELL: dwell_reg <= 15'(clamp(wdata, 16'h0000, `MAX_DWELL));
                `OFS_CLOSE: close_reg <= 14'(clamp(wdata, `MIN_CLOSE, `MAX_CLOSE));
                `OFS_RETRY: retry_reg <= 2'(clamp(wdata, 16'h0000, `MAX_RETRY));
                `OFS_NOADD: noadd_reg <= 4'(clamp(wdata, 16'h0001, `MAX_NOADD));
                `OFS_LEAK_LIM: leak_lim_reg <= 10'(clamp(wdata, 16'h0000, `MAX_LEAK_LIM));
                `OFS_LEAK_WIN: leak_win_reg <= 7'(clamp(wdata, 16'h0001, `MAX_LEAK_WIN));
                `OFS_PUMP_TO: fb_to_reg[0] <= 8'(clamp(wdata, 16'h0001, `MAX_FB_TO));
                `OFS_BLOCK_TO: fb_to_reg[1] <= 8'(clamp(wdata, 16'h0001, `MAX_FB_TO));
                default: begin
                end
            endcase
        end
    end

    // Injection sequence: open, stroke, retry and close-delay supervision
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
            delivered_reg <= '0;
            ms_cnt_reg <= '0;
            noadd_ms_reg <= '0;
            retry_cnt_reg <= '0;
            seen_reg <= 1'h0;
            done_pulse_reg <= 1'h0;
            noadd_fault_reg <= 1'h0;
        end else begin
            done_pulse_reg <= 1'h0;
            noadd_fault_reg <= 1'h0;
            case (state_reg)
                ST_IDLE: begin
                    // A stopped or paused batch refuses a new injection
                    if (start_req && !stop_reg && !pause_reg) begin
                        state_reg <= ST_ON;
                        delivered_reg <= '0;
                        ms_cnt_reg <= '0;
                        noadd_ms_reg <= '0;
                        retry_cnt_reg <= '0;
                        seen_reg <= 1'h0;
                    end
                end
                ST_ON, ST_OFF: begin
                    if (meter_edge) begin
                        delivered_reg <= delivered_reg + 1'h1;
                        seen_reg <= 1'h1;
                    end
                    if (stop_reg) begin
                        state_reg <= ST_IDLE;
                    end else if (delivered_reg >= volume_reg) begin
                        state_reg <= ST_CLOSE;
                        ms_cnt_reg <= '0;
                        done_pulse_reg <= 1'h1;
                    end else if (ms_tick_reg && !pause_reg) begin
                        if (state_reg == ST_ON && !seen_reg && noadd_ms_reg == noadd_tgt - 1'h1) begin
                            noadd_ms_reg <= '0;
                            ms_cnt_reg <= '0;
                            if (retry_cnt_reg < retry_reg) begin
                                retry_cnt_reg <= retry_cnt_reg + 1'h1;
                                state_reg <= ST_OFF;
                            end else begin
                                noadd_fault_reg <= 1'h1;
                                state_reg <= ST_CLOSE;
                            end
                        end else begin
                            if (state_reg == ST_ON && !seen_reg) begin
                                noadd_ms_reg <= noadd_ms_reg + 1'h1;
                            end
                            if (state_reg == ST_OFF) begin
                                if (ms_cnt_reg == off_tgt - 1'h1) begin
                                    ms_cnt_reg <= '0;
                                    state_reg <= ST_ON;
                                end else begin
                                    ms_cnt_reg <= ms_cnt_reg + 1'h1;
                                end
                            end else if (dwell_reg != 15'h0000) begin
                                if (ms_cnt_reg == dwell_tgt - 1'h1) begin
                                    ms_cnt_reg <= '0;
                                    state_reg <= ST_OFF;
                                end else begin
                                    ms_cnt_reg <= ms_cnt_reg + 1'h1;
                                end
                            end
                        end
                    end
                end
                ST_CLOSE: begin
                    // Trailing pulses inside the close delay still count as delivered
                    if (meter_edge) begin
                        delivered_reg <= delivered_reg + 1'h1;
                    end
                    if (ms_tick_reg) begin
                        if (ms_cnt_reg == close_tgt - 1'h1) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            ms_cnt_reg <= ms_cnt_reg + 1'h1;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Solenoid lags the state by one cycle so pause and stop can cut it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            solenoid_reg <= 1'h0;
        end else begin
            solenoid_reg <= state_reg == ST_ON && !pause_reg && !stop_reg;
        end
    end

    // Leak monitor runs only in ST_IDLE, never during injection or the close delay
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            leak_ms_reg <= '0;
            leak_cnt_reg <= '0;
        end else if (state_reg != ST_IDLE) begin
            leak_ms_reg <= '0;
            leak_cnt_reg <= '0;
        end else if (ms_tick_reg && leak_ms_reg == leak_tgt - 1'h1) begin
            leak_ms_reg <= '0;
            leak_cnt_reg <= meter_edge ? 11'h001 : 11'h000;
        end else begin
            if (ms_tick_reg) begin
                leak_ms_reg <= leak_ms_reg + 1'h1;
            end
            // Saturates just past the limit; the exact excess is not needed
            if (meter_edge && leak_cnt_reg <= 11'(leak_lim_reg)) begin
                leak_cnt_reg <= leak_cnt_reg + 1'h1;
            end
        end
    end

    assign leak_cond = state_reg == ST_IDLE && leak_cnt_reg > 11'(leak_lim_reg);

    // Pump and block valve feedback supervisors
    assign fb_in = {block_fb, pump_fb};

    for (genvar i = 0; i < 2; i++) begin : g_fb
        logic [1:0] sync_reg;
        logic [17:0] ms_reg;
        logic [17:0] tgt;
        logic demand;

        assign tgt = 18'(fb_to_reg[i]) * `SEC_MS;
        assign demand = (i == 0) ? pump_demand_reg : block_demand_reg;

        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                sync_reg <= '0;
            end else begin
                sync_reg <= {sync_reg[0], fb_in[i]};
            end
        end

        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                ms_reg <= '0;
            end else if (!demand || sync_reg[1]) begin
                ms_reg <= '0;
            end else if (ms_tick_reg && ms_reg != tgt) begin
                ms_reg <= ms_reg + 1'h1;
            end
        end

        assign fb_level[i] = sync_reg[1];
        assign fb_fault[i] = ms_reg == tgt;
    end

    assign cond = {fb_fault[1], fb_fault[0], noadd_fault_reg, leak_cond};

    // Per-alarm latch and action decode
    for (genvar a = 0; a < 4; a++) begin : g_alarm
        action_t act;
        logic hit;
        logic latch_reg;

        assign act = action_t'(action_reg[2*a +: 2]);
        assign hit = cond[a] && act != ACT_DISABLED;

        // A new occurrence in the clearing cycle keeps the alarm
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                latch_reg <= 1'h0;
            end else if (hit) begin
                latch_reg <= 1'h1;
            end else if (clear_req) begin
                latch_reg <= 1'h0;
            end
        end

        assign alarm_vec[a] = latch_reg;
        assign raise_vec[a] = hit && !latch_reg;
        assign ind_vec[a] = latch_reg && act != ACT_DISABLED;
        assign sd_vec[a] = latch_reg && (act == ACT_SHUTDOWN || act == ACT_PAUSE);
        assign stop_vec[a] = latch_reg && act == ACT_SHUTDOWN;
        assign pause_vec[a] = latch_reg && act == ACT_PAUSE;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ind_reg <= 1'h0;
            sd_reg <= 1'h0;
            stop_reg <= 1'h0;
            pause_reg <= 1'h0;
        end else begin
            ind_reg <= |ind_vec;
            sd_reg <= |sd_vec;
            stop_reg <= |stop_vec;
            // Stopping outranks pausing when both are configured
            pause_reg <= |pause_vec && !(|stop_vec);
        end
    end

    // Sticky event bits, write one to clear; a set in the same cycle wins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_st_reg <= '0;
            irq_reg <= 1'h0;
        end else begin
            irq_st_reg <= (irq_st_reg & ~((wr_en && addr == `OFS_IRQ_ST) ? wdata[4:0] : 5'h00))
                | {done_pulse_reg, raise_vec};
            irq_reg <= |(irq_st_reg & irq_mask_reg);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= '0;
        end else if (rd_en) begin
            case (addr)
                `OFS_CTRL: rdata_reg <= {12'h000, 1'h0, block_demand_reg, pump_demand_reg, 1'h0};
                `OFS_STATUS: rdata_reg <= {5'h00, fb_level, alarm_vec, retry_cnt_reg, state_reg, solenoid_reg};
                `OFS_IRQ_ST: rdata_reg <= {11'h000, irq_st_reg};
                `OFS_IRQ_MASK: rdata_reg <= {11'h000, irq_mask_reg};
                `OFS_ACTION: rdata_reg <= {8'h00, action_reg};
                `OFS_VOLUME: rdata_reg <= 16'(volume_reg);
                `OFS_DWELL: rdata_reg <= {1'h0, dwell_reg};
                `OFS_CLOSE: rdata_reg <= {2'h0, close_reg};
                `OFS_RETRY: rdata_reg <= {14'h0000, retry_reg};
                `OFS_NOADD: rdata_reg <= {12'h000, noadd_reg};
                `OFS_LEAK_LIM: rdata_reg <= {6'h00, leak_lim_reg};
                `OFS_LEAK_WIN: rdata_reg <= {9'h000, leak_win_reg};
                `OFS_PUMP_TO: rdata_reg <= {8'h00, fb_to_reg[0]};
                `OFS_BLOCK_TO: rdata_reg <= {8'h00, fb_to_reg[1]};
                `OFS_DELIVERED: rdata_reg <= 16'(delivered_reg);
                default: rdata_reg <= '0;
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end

    assign rdata = rdata_reg;
    assign solenoid = solenoid_reg;
    assign alarm_ind = ind_reg;
    assign alarm_shutdown = sd_reg;
    assign batch_stop = stop_reg;
    assign batch_pause = pause_reg;
    assign irq = irq_reg;

endmodule
`default_nettype wire

// ### sim/addsol_sva.sv
`default_nettype none
module addsol_sva #(
    parameter int MS_CYCLES = 10
) (
    input wire logic clk, // clock
    input wire logic reset_n, // reset
    input wire logic [3:0] addr, // bus address
    input wire logic [15:0] wdata, // bus data
    input wire logic wr_en, // write strobe
    input wire logic solenoid, // valve drive
    input wire logic alarm_ind, // indication
    input wire logic alarm_shutdown, // shutdown
    input wire logic batch_stop, // stopped
    input wire logic batch_pause, // paused
    input wire logic irq // interrupt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] act_q, mask_q, dwell_q;
    int on_cnt;
    // Shadow copies, so outputs can be judged against the settings in force
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            act_q <= 16'h0002;
            mask_q <= 16'h0000;
            dwell_q <= 16'h0000;
        end else if (wr_en) begin
            if (addr == 4'h4) act_q <= wdata & 16'h00FF;
            if (addr == 4'h3) mask_q <= wdata & 16'h001F;
            if (addr == 4'h6) dwell_q <= (wdata > 16'h7FFF) ? 16'h7FFF : wdata;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) on_cnt <= 0;
        else on_cnt <= solenoid ? on_cnt + 1 : 0;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_start;
        wr_en && addr == 4'h0 && wdata[0];
    endsequence
    // Four cycles leave room for the solenoid register, which drops one cycle after batch_stop rises
    sequence s_stop_held;
        batch_stop [*4];
    endsequence
    sequence s_pause_held;
        batch_pause [*4];
    endsequence
    chk_stop_outputs: assert property (batch_stop |-> alarm_shutdown && alarm_ind)
        else $error("stop without shutdown outputs");
    chk_pause_outputs: assert property (batch_pause |-> alarm_shutdown && alarm_ind && !batch_stop)
        else $error("pause without outputs or with stop");
    chk_shut_ind: assert property (alarm_shutdown |-> alarm_ind)
        else $error("shutdown without indication");
    chk_ind_enabled: assert property (alarm_ind |-> (act_q | $past(act_q)) != 16'h0000)
        else $error("indication while all actions disabled");
    chk_stop_closed: assert property (s_stop_held |-> !solenoid)
        else $error("solenoid open in stopped batch");
    chk_pause_closed: assert property (s_pause_held |-> !solenoid)
        else $error("solenoid open in paused batch");
    chk_dwell_on: assert property (solenoid && dwell_q != 16'h0000 |-> on_cnt < int'(dwell_q) * MS_CYCLES)
        else $error("solenoid on longer than dwell");
    chk_irq_masked: assert property (irq |-> (mask_q | $past(mask_q)) != 16'h0000)
        else $error("interrupt with all sources masked");
    cov_start: cover property (s_start ##[1:4] solenoid);
endmodule
bind additive_solenoid_alarm_supervisor addsol_sva #(.MS_CYCLES(MS_CYCLES)) i_addsol_sva (.clk(clk),
    .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .solenoid(solenoid), .alarm_ind(alarm_ind),
    .alarm_shutdown(alarm_shutdown), .batch_stop(batch_stop), .batch_pause(batch_pause), .irq(irq));
`default_nettype wire

// ### sim/addsol_far_model.sv
`default_nettype none
module addsol_far_model (
    input wire logic clk, // clock
    input wire logic solenoid, // valve drive
    input wire logic [1:0] mode, // 0 dry, 1 flow while open, 2 leak
    input wire logic [7:0] period, // cycles per meter pulse
    input wire logic pump_run, // pump really running
    input wire logic block_open, // block valve really open
    output logic meter_pulse, // meter pin
    output logic pump_fb, // pump contact
    output logic block_fb // block contact
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    initial meter_pulse = 1'b0;
    // Pulses two cycles wide so the synchroniser never misses one
    always @(posedge clk) begin
        if (mode == 2'd2 || (mode == 2'd1 && solenoid)) begin
            cnt <= (cnt + 1 >= int'(period)) ? 0 : cnt + 1;
            meter_pulse <= cnt < 2;
        end else begin
            meter_pulse <= 1'b0;
        end
    end
    assign pump_fb = pump_run;
    assign block_fb = block_open;
endmodule
`default_nettype wire

// ### sim/test_additive_solenoid_alarm_supervisor.sv
`default_nettype none
module test_additive_solenoid_alarm_supervisor;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, reset_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, sol_d = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata, d;
    logic meter_pulse, pump_fb, block_fb, solenoid, alarm_ind, alarm_shutdown, batch_stop, batch_pause, irq;
    logic [1:0] mode = 2'd0;
    logic [7:0] period = 8'd40;
    logic pump_run = 1'b0, block_open = 1'b0;
    int errors = 0, tests_run = 0, rises = 0, run_len = 0, i, v;
    int runs[$];
    logic [15:0] dflt[10] = '{16'h0002, 16'h0001, 16'h0000, 16'h01F4, 16'h0002, 16'h0002, 16'h0064,
        16'h003C, 16'h000F, 16'h000F};
    logic [3:0] ca[7] = '{4'h6, 4'h7, 4'h7, 4'h8, 4'h9, 4'hB, 4'hC};
    logic [15:0] cw[7] = '{16'hFFFF, 16'h2711, 16'h0001, 16'h0003, 16'h0000, 16'h0064, 16'h0100};
    logic [15:0] ce[7] = '{16'h7FFF, 16'h2710, 16'h01F4, 16'h0002, 16'h0001, 16'h0063, 16'h00FF};
    additive_solenoid_alarm_supervisor #(.MS_CYCLES(10)) i_additive_solenoid_alarm_supervisor (.clk(clk),
        .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .meter_pulse(meter_pulse), .pump_fb(pump_fb), .block_fb(block_fb), .solenoid(solenoid),
        .alarm_ind(alarm_ind), .alarm_shutdown(alarm_shutdown), .batch_stop(batch_stop),
        .batch_pause(batch_pause), .irq(irq));
    addsol_far_model i_addsol_far_model (.clk(clk), .solenoid(solenoid), .mode(mode), .period(period),
        .pump_run(pump_run), .block_open(block_open), .meter_pulse(meter_pulse), .pump_fb(pump_fb),
        .block_fb(block_fb));
    initial forever #50 clk = ~clk;
    // Run lengths of the solenoid level, sampled away from the active edge
    always @(negedge clk) begin
        if (solenoid !== sol_d) begin
            runs.push_back(run_len);
            run_len = 1;
            if (solenoid === 1'b1) rises++;
        end else run_len++;
        sol_d = solenoid;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] w);
        addr <= a;
        wdata <= w;
        wr_en <= 1'b1;
        cyc(1);
        wr_en <= 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] r);
        addr <= a;
        rd_en <= 1'b1;
        cyc(1);
        rd_en <= 1'b0;
        #1 r = rdata;
        cyc(1);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [15:0] exp, input string what);
        rd(a, d);
        chk(d, exp, what);
    endtask
    task automatic wait_hi(ref logic s, input int n);
        for (i = 0; i < n && s !== 1'b1; i++) cyc(1);
    endtask
    function automatic logic [15:0] outs();
        return {12'h000, alarm_ind, alarm_shutdown, batch_stop, batch_pause};
    endfunction
    function automatic logic [15:0] exp_out(input int act);
        case (act)
            1: return 16'h0008;
            2: return 16'h000E;
            3: return 16'h000D;
            default: return 16'h0000;
        endcase
    endfunction
    task automatic inject(input logic [15:0] dw, input int vol, input logic [7:0] per);
        wr(4'h6, dw);
        wr(4'h5, 16'(vol));
        wr(4'h3, 16'h0010);
        mode <= 2'd1;
        period <= per;
        runs.delete();
        rises = 0;
        wr(4'h0, 16'h0001);
        wait_hi(irq, 3000);
        chk({15'h0000, irq}, 16'h0001, "done interrupt");
        wr(4'h2, 16'h0010);
        cyc(2);
        chk({15'h0000, irq}, 16'h0000, "done cleared");
        mode <= 2'd0;
        // Close delay of 500 ms must run out before the next start
        cyc(5100);
    endtask
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        cyc(90000);
        errors++;
        final_report();
    end
    initial begin
        void'($urandom(54));
        cyc(8);
        reset_n <= 1'b1;
        cyc(1);
        foreach (dflt[k]) rchk(4'(k + 4), dflt[k], "default");
        rchk(4'hF, 16'h0000, "unmapped");
        foreach (ca[k]) begin
            wr(ca[k], cw[k]);
            rchk(ca[k], ce[k], "clamp");
        end
        $display("Defaults and limits done");
        v = 2 + $urandom % 4;
        inject(16'h0000, v, 8'd40);
        chk(16'(rises), 16'h0001, "held open");
        rchk(4'hE, 16'(v), "delivered");
        v = 7 + $urandom % 3;
        inject(16'h0002, v, 8'd7);
        chk(16'(runs[2]), 16'd20, "off time");
        chk(16'(runs[3]), 16'd20, "on time");
        chk(16'(rises >= 3), 16'h0001, "strokes repeat");
        $display("Injection done");
        v = $urandom % 2;
        wr(4'h8, 16'(v));
        wr(4'h9, 16'h0001);
        wr(4'h6, 16'h0000);
        wr(4'h4, 16'h0004);
        runs.delete();
        rises = 0;
        wr(4'h0, 16'h0001);
        wait_hi(alarm_ind, 25000);
        chk(16'(rises), 16'(v + 1), "retries");
        rd(4'h1, d);
        chk({12'h000, d[8:5]}, 16'h0002, "no additive");
        chk(outs(), exp_out(1), "display only");
        chk({15'h0000, irq}, 16'h0000, "masked");
        rchk(4'h2, 16'h0002, "event bit");
        wr(4'h3, 16'h0012);
        cyc(2);
        chk({15'h0000, irq}, 16'h0001, "unmasked");
        wr(4'h2, 16'h0002);
        cyc(2);
        chk({15'h0000, irq}, 16'h0000, "cleared");
        cyc(5100);
        wr(4'h0, 16'h0008);
        cyc(2);
        chk(outs(), 16'h0000, "alarm cleared");
        $display("No additive done");
        wr(4'hA, 16'(1 + $urandom % 4));
        wr(4'hB, 16'h0001);
        mode <= 2'd2;
        period <= 8'd30;
        // Disabled comes last: a leftover window count re-raises at once
        for (int k = 1; k <= 4; k++) begin
            wr(4'h4, 16'(k % 4));
            wait_hi(alarm_ind, 11000);
            cyc(3);
            chk(outs(), exp_out(k % 4), "leak action");
            wr(4'h4, 16'h0000);
            wr(4'h0, 16'h0008);
        end
        mode <= 2'd0;
        $display("Leak actions done");
        wr(4'hC, 16'h0001);
        wr(4'hD, 16'h0002);
        wr(4'h4, 16'h0050);
        wr(4'h0, 16'h0006);
        wait_hi(alarm_ind, 11000);
        chk(16'(i > 9900 && i < 10100), 16'h0001, "pump timeout");
        rd(4'h1, d);
        chk({12'h000, d[8:5]}, 16'h0004, "block later");
        $display("Feedback done");
        final_report();
    end
endmodule
`default_nettype wire
